// ---- inc/status_flag_pkg.sv ----
// Shared constants and types for the status-word flag logic
package status_flag_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int STATUS_W = 8;
  localparam int BYTE_W   = 8;
  localparam int WORD_W   = 16;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int BIT_CARRY    = 0;
  localparam int BIT_PAD_LO   = 1;
  localparam int BIT_CHAIN_HL = 2;
  localparam int BIT_CHAIN_A  = 3;
  localparam int BIT_HALF     = 4;
  localparam int BIT_SKIP     = 5;
  localparam int BIT_ZERO     = 6;
  localparam int BIT_PAD_HI   = 7;

  // ----------------------------------------------------------------
  // Reset value and masks
  // ----------------------------------------------------------------
  localparam logic [STATUS_W-1:0] STATUS_RESET  = 8'h00;
  // Bits that hold state; bits 7 and 1 are always zero
  localparam logic [STATUS_W-1:0] LIVE_MASK     = 8'h7d;
  // Flags kept when an instruction does not affect them
  localparam logic [STATUS_W-1:0] PRESERVE_MASK = 8'h51;
  // Single-flag masks
  localparam logic [STATUS_W-1:0] M_CARRY       = 8'h01;
  localparam logic [STATUS_W-1:0] M_CHAIN_HL    = 8'h04;
  localparam logic [STATUS_W-1:0] M_CHAIN_A     = 8'h08;
  localparam logic [STATUS_W-1:0] M_HALF        = 8'h10;
  localparam logic [STATUS_W-1:0] M_SKIP        = 8'h20;
  localparam logic [STATUS_W-1:0] M_ZERO        = 8'h40;
  localparam logic [STATUS_W-1:0] M_NONE        = 8'h00;

  // ----------------------------------------------------------------
  // Instruction flag groups
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    GRP_OTHER,
    GRP_ARITH,
    GRP_DECIMAL_ADJ,
    GRP_LOGIC,
    GRP_SKIP_ARITH,
    GRP_TEST_LOGIC,
    GRP_INC_DEC,
    GRP_SHIFT,
    GRP_SHIFT_SKIP,
    GRP_FORCE_CARRY,
    GRP_DROP_CARRY,
    GRP_MOVE_A,
    GRP_MOVE_L,
    GRP_PAIR_LOAD_HL,
    GRP_BIT_TEST,
    GRP_SKIP_RETURN
  } flag_group_type;

endpackage

// ---- src/flag_source_calc.sv ----
// Raw zero, half-carry and carry sources from the ALU result
`timescale 1ns/1ps
module flag_source_calc (
  // ALU result and carries
  input  wire logic [status_flag_pkg::WORD_W-1:0] alu_result,
  input  wire logic                               word_op,
  input  wire logic                               carry_bit3,
  input  wire logic                               carry_bit7,
  input  wire logic                               carry_bit15,
  // Flag sources
  output logic                                    zero_src,
  output logic                                    half_src,
  output logic                                    carry_src
);

  // ------------------------------------------------------------------
  // Width-dependent sources
  // ------------------------------------------------------------------
  // Byte ops ignore the upper byte, which may hold stale ALU data
  always_comb begin
    if (word_op) begin
      zero_src  = (alu_result == '0);
      carry_src = carry_bit15;
    end else begin
      zero_src  = (alu_result[status_flag_pkg::BYTE_W-1:0] == '0);
      carry_src = carry_bit7;
    end
    half_src = carry_bit3;
  end

endmodule

// ---- src/status_push_reg.sv ----
// Holds the status word pushed to the stack when an interrupt is taken
`timescale 1ns/1ps
module status_push_reg (
  // Clock and reset
  input  wire logic                                 ref_clk,
  input  wire logic                                 srst,
  // Capture request
  input  wire logic                                 irq_accept,
  input  wire logic [status_flag_pkg::STATUS_W-1:0] status_now,
  // Push towards the stack
  output logic                                      push_valid,
  output logic      [status_flag_pkg::STATUS_W-1:0] push_data
);

  // ------------------------------------------------------------------
  // Push strobe
  // ------------------------------------------------------------------
  // One-cycle pulse; the stack writer must take it in that cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      push_valid <= 1'b0;
    end else begin
      push_valid <= irq_accept;
    end
  end

  // ------------------------------------------------------------------
  // Push data
  // ------------------------------------------------------------------
  // Captures the word as it stood before any same-cycle update
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      push_data <= status_flag_pkg::STATUS_RESET;
    end else if (irq_accept) begin
      push_data <= status_now;
    end
  end

endmodule

// ---- src/status_flag_update_logic.sv ----
// Status-word flag update logic of an 8-bit controller core
//
// Function
// - Zero flag bit 6 is set for an all-zero result, else cleared.
// - Skip flag bit 5 follows the skip condition of affecting instructions; skip-return sets it.
// - Half-carry bit 4 follows carry out of or borrow into bit 3.
// - Chain flag A bit 3 set by accumulator immediate moves, cleared by others.
// - Chain flag HL bit 2 set by L immediate move or HL pair load.
// - Carry bit 0 follows carry or borrow at bit 7 or bit 15.
// - Arithmetic updates zero, half-carry, carry; clears skip and chain flags.
// - Logical ops update only zero; clear skip and chains; keep carries.
// - Skip-arithmetic and compares update zero, skip, half-carry, carry.
// - Shifts and rotates update only carry; clear skip and chain flags.
// - Bit and flag tests update only skip; clear chains, keep others.
// - Force-carry sets carry, drop-carry clears it; skip and chains cleared.
// - Interrupt pushes whole status word; interrupt return restores it.
// - Reset clears every status bit.
`timescale 1ns/1ps
module status_flag_update_logic (
  // Clock and reset
  input  wire logic                                  ref_clk,
  input  wire logic                                  srst,
  // Instruction retire
  input  wire logic                                  instr_valid,
  input  wire status_flag_pkg::flag_group_type       instr_group,
  input  wire logic                                  word_op,
  // ALU results
  input  wire logic [status_flag_pkg::WORD_W-1:0]    alu_result,
  input  wire logic                                  carry_bit3,
  input  wire logic                                  carry_bit7,
  input  wire logic                                  carry_bit15,
  input  wire logic                                  skip_cond,
  // Interrupt save and restore
  input  wire logic                                  irq_accept,
  input  wire logic                                  reti_valid,
  input  wire logic [status_flag_pkg::STATUS_W-1:0]  restore_data,
  output logic                                       push_valid,
  output logic      [status_flag_pkg::STATUS_W-1:0]  push_data,
  // Status word
  output logic      [status_flag_pkg::STATUS_W-1:0]  status_word
);

  // ------------------------------------------------------------------
  // Group decoding
  // ------------------------------------------------------------------
  // Returns the set of zero, skip, half-carry and carry flags that a
  // group writes; the chain flags are written by every instruction.
  function automatic logic [status_flag_pkg::STATUS_W-1:0] group_affects(
    input status_flag_pkg::flag_group_type grp
  );
    logic [status_flag_pkg::STATUS_W-1:0] m;
    m = status_flag_pkg::M_NONE;
    case (grp)
      status_flag_pkg::GRP_ARITH,
      status_flag_pkg::GRP_DECIMAL_ADJ: begin
        m = status_flag_pkg::M_ZERO | status_flag_pkg::M_HALF | status_flag_pkg::M_CARRY;
      end
      status_flag_pkg::GRP_LOGIC: begin
        m = status_flag_pkg::M_ZERO;
      end
      status_flag_pkg::GRP_SKIP_ARITH: begin
        m = status_flag_pkg::M_ZERO | status_flag_pkg::M_SKIP | status_flag_pkg::M_HALF
          | status_flag_pkg::M_CARRY;
      end
      status_flag_pkg::GRP_TEST_LOGIC: begin
        m = status_flag_pkg::M_ZERO | status_flag_pkg::M_SKIP;
      end
      status_flag_pkg::GRP_INC_DEC: begin
        m = status_flag_pkg::M_ZERO | status_flag_pkg::M_SKIP | status_flag_pkg::M_HALF;
      end
      status_flag_pkg::GRP_SHIFT,
      status_flag_pkg::GRP_FORCE_CARRY,
      status_flag_pkg::GRP_DROP_CARRY: begin
        m = status_flag_pkg::M_CARRY;
      end
      status_flag_pkg::GRP_SHIFT_SKIP: begin
        m = status_flag_pkg::M_SKIP | status_flag_pkg::M_CARRY;
      end
      status_flag_pkg::GRP_BIT_TEST,
      status_flag_pkg::GRP_SKIP_RETURN: begin
        m = status_flag_pkg::M_SKIP;
      end
      default: begin
        m = status_flag_pkg::M_NONE;
      end
    endcase
    return m;
  endfunction

  // ------------------------------------------------------------------
  // Raw flag sources
  // ------------------------------------------------------------------
  logic                                   zero_src;
  logic                                   half_src;
  logic                                   carry_src;
  logic [status_flag_pkg::STATUS_W-1:0]   status_r;
  logic [status_flag_pkg::STATUS_W-1:0]   status_nxt;
  logic [status_flag_pkg::STATUS_W-1:0]   affect_mask;
  logic [status_flag_pkg::STATUS_W-1:0]   calc_word;
  logic                                   carry_val;
  logic                                   skip_val;
  logic                                   chain_a_val;
  logic                                   chain_hl_val;

  flag_source_calc u_calc (
    .alu_result  (alu_result),
    .word_op     (word_op),
    .carry_bit3  (carry_bit3),
    .carry_bit7  (carry_bit7),
    .carry_bit15 (carry_bit15),
    .zero_src    (zero_src),
    .half_src    (half_src),
    .carry_src   (carry_src)
  );

  // ------------------------------------------------------------------
  // Per-group flag values
  // ------------------------------------------------------------------
  // Carry manipulation overrides the ALU carry entirely
  always_comb begin
    case (instr_group)
      status_flag_pkg::GRP_FORCE_CARRY: carry_val = 1'b1;
      status_flag_pkg::GRP_DROP_CARRY:  carry_val = 1'b0;
      default:                          carry_val = carry_src;
    endcase
  end

  // Skip-return always leaves the skip flag set
  always_comb begin
    case (instr_group)
      status_flag_pkg::GRP_SKIP_RETURN: skip_val = 1'b1;
      default:                          skip_val = skip_cond;
    endcase
  end

  // Chain flags; any other instruction clears both
  assign chain_a_val  = (instr_group == status_flag_pkg::GRP_MOVE_A);
  assign chain_hl_val = (instr_group == status_flag_pkg::GRP_MOVE_L)
                     || (instr_group == status_flag_pkg::GRP_PAIR_LOAD_HL);

  // Candidate word built from the fresh sources
  always_comb begin
    calc_word                                = status_flag_pkg::STATUS_RESET;
    calc_word[status_flag_pkg::BIT_ZERO]     = zero_src;
    calc_word[status_flag_pkg::BIT_SKIP]     = skip_val;
    calc_word[status_flag_pkg::BIT_HALF]     = half_src;
    calc_word[status_flag_pkg::BIT_CHAIN_A]  = chain_a_val;
    calc_word[status_flag_pkg::BIT_CHAIN_HL] = chain_hl_val;
    calc_word[status_flag_pkg::BIT_CARRY]    = carry_val;
  end

  assign affect_mask = group_affects(instr_group);

  // ------------------------------------------------------------------
  // Next status word
  // ------------------------------------------------------------------
  // Restore from the stack wins over a retiring instruction, because the
  // return is the last thing the core does in that cycle. Unaffected
  // zero, half-carry and carry are kept; skip and chains fall to zero.
  always_comb begin
    status_nxt = status_r;
    if (reti_valid) begin
      status_nxt = restore_data & status_flag_pkg::LIVE_MASK;
    end else if (instr_valid) begin
      status_nxt = (status_r & ~affect_mask & status_flag_pkg::PRESERVE_MASK)
                 | (calc_word & affect_mask)
                 | (calc_word & (status_flag_pkg::M_CHAIN_A | status_flag_pkg::M_CHAIN_HL));
    end
    status_nxt = status_nxt & status_flag_pkg::LIVE_MASK;
  end

  // ------------------------------------------------------------------
  // Status register
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_r <= status_flag_pkg::STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign status_word = status_r;

  // ------------------------------------------------------------------
  // Interrupt push
  // ------------------------------------------------------------------
  status_push_reg u_push (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .irq_accept (irq_accept),
    .status_now (status_r),
    .push_valid (push_valid),
    .push_data  (push_data)
  );

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // Qualifier for an instruction that actually writes the flags; a reset
  // seen on the same edge wins, so that cycle is not a retire
  logic retire_ok;
  assign retire_ok = instr_valid && !reti_valid && !srst;

  a_reset_clears_word: assert property (
    @(posedge ref_clk) srst |=> (status_word == status_flag_pkg::STATUS_RESET))
    else $error("Status word not cleared after reset");

  a_pad_bits_zero: assert property (
    @(posedge ref_clk) disable iff (srst)
    !status_word[status_flag_pkg::BIT_PAD_HI] && !status_word[status_flag_pkg::BIT_PAD_LO])
    else $error("Padding bit of status word is set");

  a_arith_flag_update: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok && instr_group == status_flag_pkg::GRP_ARITH |=>
      status_word[status_flag_pkg::BIT_ZERO] == $past(zero_src)
      && status_word[status_flag_pkg::BIT_HALF] == $past(carry_bit3)
      && !status_word[status_flag_pkg::BIT_SKIP]
      && !status_word[status_flag_pkg::BIT_CHAIN_A]
      && !status_word[status_flag_pkg::BIT_CHAIN_HL])
    else $error("Arithmetic flag update wrong");

  a_zero_from_result: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok && instr_group == status_flag_pkg::GRP_LOGIC && !word_op |=>
      status_word[status_flag_pkg::BIT_ZERO] == ($past(alu_result[status_flag_pkg::BYTE_W-1:0]) == '0))
    else $error("Zero flag does not match byte result");

  a_carry_width_sel: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok && instr_group == status_flag_pkg::GRP_ARITH |=>
      status_word[status_flag_pkg::BIT_CARRY] == ($past(word_op) ? $past(carry_bit15) : $past(carry_bit7)))
    else $error("Carry flag taken from wrong bit");

  a_skip_tracks_cond: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok && (instr_group == status_flag_pkg::GRP_SKIP_ARITH
                  || instr_group == status_flag_pkg::GRP_BIT_TEST) |=>
      status_word[status_flag_pkg::BIT_SKIP] == $past(skip_cond))
    else $error("Skip flag does not follow condition");

  a_skip_arith_all: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok && instr_group == status_flag_pkg::GRP_SKIP_ARITH |=>
      status_word[status_flag_pkg::BIT_HALF] == $past(half_src)
      && status_word[status_flag_pkg::BIT_CARRY] == $past(carry_src)
      && (status_word & (status_flag_pkg::M_CHAIN_A | status_flag_pkg::M_CHAIN_HL)) == '0)
    else $error("Skip-arithmetic flag update wrong");

  a_half_from_bit3: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok && instr_group == status_flag_pkg::GRP_INC_DEC |=>
      status_word[status_flag_pkg::BIT_HALF] == $past(carry_bit3)
      && status_word[status_flag_pkg::BIT_CARRY] == $past(status_word[status_flag_pkg::BIT_CARRY]))
    else $error("Half-carry flag wrong after increment or decrement");

  a_logic_keeps_carry: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok && instr_group == status_flag_pkg::GRP_LOGIC |=>
      $stable(status_word[status_flag_pkg::BIT_HALF]) && $stable(status_word[status_flag_pkg::BIT_CARRY])
      && !status_word[status_flag_pkg::BIT_SKIP])
    else $error("Logical op disturbed carry flags");

  a_shift_only_carry: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok && instr_group == status_flag_pkg::GRP_SHIFT |=>
      status_word[status_flag_pkg::BIT_CARRY] == $past(carry_src)
      && $stable(status_word[status_flag_pkg::BIT_ZERO]) && $stable(status_word[status_flag_pkg::BIT_HALF])
      && !status_word[status_flag_pkg::BIT_SKIP])
    else $error("Shift flag update wrong");

  a_bit_test_skip: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok && instr_group == status_flag_pkg::GRP_BIT_TEST |=>
      ((status_word ^ $past(status_word)) & status_flag_pkg::PRESERVE_MASK) == '0)
    else $error("Bit test changed a kept flag");

  a_force_drop_carry: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok && (instr_group == status_flag_pkg::GRP_FORCE_CARRY
                  || instr_group == status_flag_pkg::GRP_DROP_CARRY) |=>
      status_word[status_flag_pkg::BIT_CARRY] == ($past(instr_group) == status_flag_pkg::GRP_FORCE_CARRY))
    else $error("Carry manipulation gave wrong carry");

  a_chain_a_set: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok |=> status_word[status_flag_pkg::BIT_CHAIN_A]
                  == ($past(instr_group) == status_flag_pkg::GRP_MOVE_A))
    else $error("Chain flag A wrong");

  a_chain_hl_set: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok |=> status_word[status_flag_pkg::BIT_CHAIN_HL]
                  == ($past(instr_group) == status_flag_pkg::GRP_MOVE_L
                      || $past(instr_group) == status_flag_pkg::GRP_PAIR_LOAD_HL))
    else $error("Chain flag HL wrong");

  a_other_clears_skip: assert property (
    @(posedge ref_clk) disable iff (srst)
    retire_ok && instr_group == status_flag_pkg::GRP_OTHER |=>
      (status_word & ~status_flag_pkg::PRESERVE_MASK) == '0
      && ((status_word ^ $past(status_word)) & status_flag_pkg::PRESERVE_MASK) == '0)
    else $error("Unlisted instruction changed flags wrongly");

  a_push_restore: assert property (
    @(posedge ref_clk) disable iff (srst)
    (!srst && irq_accept |=> push_valid && push_data == $past(status_word))
    and (!srst && reti_valid |=> status_word == ($past(restore_data) & status_flag_pkg::LIVE_MASK)))
    else $error("Status push or restore wrong");

  // Sampled reset is excluded too: the edge that releases reset still clears the word
  a_idle_holds_word: assert property (
    @(posedge ref_clk) disable iff (srst)
    !srst && !instr_valid && !reti_valid |=> $stable(status_word))
    else $error("Status word changed with no instruction");

endmodule

// ---- tb/tb_top.sv ----
// Self-checking testbench for the status-word flag update logic
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // Stimulus rows: group, width, result, carries, skip, expected word
  // ----------------------------------------------------------------
  typedef struct packed {
    status_flag_pkg::flag_group_type grp;
    logic                            wop;
    logic [15:0]                     res;
    logic                            c3;
    logic                            c7;
    logic                            c15;
    logic                            sk;
    logic [7:0]                      exp_word;
  } row_type;

  // Each row's expectation builds on the word left by the row before it
  localparam row_type ROWS [18] = '{
    '{status_flag_pkg::GRP_ARITH,        1'b0, 16'h0000, 1'b1, 1'b1, 1'b0, 1'b0, 8'h51},
    '{status_flag_pkg::GRP_LOGIC,        1'b0, 16'h0005, 1'b0, 1'b0, 1'b0, 1'b1, 8'h11},
    '{status_flag_pkg::GRP_MOVE_A,       1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 8'h19},
    '{status_flag_pkg::GRP_MOVE_L,       1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 8'h15},
    '{status_flag_pkg::GRP_PAIR_LOAD_HL, 1'b1, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 8'h15},
    '{status_flag_pkg::GRP_OTHER,        1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b1, 8'h11},
    '{status_flag_pkg::GRP_SHIFT,        1'b0, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b1, 8'h10},
    '{status_flag_pkg::GRP_FORCE_CARRY,  1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 8'h11},
    '{status_flag_pkg::GRP_BIT_TEST,     1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b1, 8'h31},
    '{status_flag_pkg::GRP_DROP_CARRY,   1'b0, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b0, 8'h10},
    '{status_flag_pkg::GRP_SKIP_ARITH,   1'b1, 16'h0100, 1'b0, 1'b0, 1'b1, 1'b1, 8'h21},
    '{status_flag_pkg::GRP_ARITH,        1'b1, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b0, 8'h40},
    '{status_flag_pkg::GRP_ARITH,        1'b0, 16'hff00, 1'b0, 1'b0, 1'b1, 1'b0, 8'h40},
    '{status_flag_pkg::GRP_TEST_LOGIC,   1'b0, 16'h0001, 1'b0, 1'b0, 1'b0, 1'b1, 8'h20},
    '{status_flag_pkg::GRP_INC_DEC,      1'b0, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b0, 8'h50},
    '{status_flag_pkg::GRP_DECIMAL_ADJ,  1'b0, 16'h0003, 1'b0, 1'b1, 1'b0, 1'b0, 8'h01},
    '{status_flag_pkg::GRP_SHIFT_SKIP,   1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b1, 8'h20},
    '{status_flag_pkg::GRP_SKIP_RETURN,  1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 8'h20}
  };

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                            ref_clk = 1'b0;
  logic                            srst = 1'b1;
  logic                            instr_valid = 1'b0;
  status_flag_pkg::flag_group_type instr_group = status_flag_pkg::GRP_OTHER;
  logic                            word_op = 1'b0;
  logic [15:0]                     alu_result = 16'h0000;
  logic                            carry_bit3 = 1'b0;
  logic                            carry_bit7 = 1'b0;
  logic                            carry_bit15 = 1'b0;
  logic                            skip_cond = 1'b0;
  logic                            irq_accept = 1'b0;
  logic                            reti_valid = 1'b0;
  logic [7:0]                      restore_data = 8'h00;
  logic                            push_valid;
  logic [7:0]                      push_data;
  logic [7:0]                      status_word;
  int                              bad_count = 0;
  int                              cmp_count = 0;

  // 20 MHz core clock
  always #25 ref_clk = ~ref_clk;

  status_flag_update_logic u_status_flag_update_logic (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .instr_valid  (instr_valid),
    .instr_group  (instr_group),
    .word_op      (word_op),
    .alu_result   (alu_result),
    .carry_bit3   (carry_bit3),
    .carry_bit7   (carry_bit7),
    .carry_bit15  (carry_bit15),
    .skip_cond    (skip_cond),
    .irq_accept   (irq_accept),
    .reti_valid   (reti_valid),
    .restore_data (restore_data),
    .push_valid   (push_valid),
    .push_data    (push_data),
    .status_word  (status_word)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Presents one instruction; caller already stands on a rising edge
  task automatic put_row(input row_type rw);
    instr_valid <= 1'b1;
    instr_group <= rw.grp;
    word_op     <= rw.wop;
    alu_result  <= rw.res;
    carry_bit3  <= rw.c3;
    carry_bit7  <= rw.c7;
    carry_bit15 <= rw.c15;
    skip_cond   <= rw.sk;
  endtask

  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge ref_clk);
    bad_count++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    check({8'h00, status_word}, 16'h0000);
    check({8'h00, push_data}, 16'h0000);
    check({15'h0000, push_valid}, 16'h0000);
    // Table rows, one idle cycle between instructions
    foreach (ROWS[i]) begin
      @(posedge ref_clk);
      put_row(ROWS[i]);
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      @(negedge ref_clk);
      check({8'h00, status_word}, {8'h00, ROWS[i].exp_word});
    end
    // Back to back, with an interrupt taken beside the second one
    @(posedge ref_clk);
    put_row('{status_flag_pkg::GRP_ARITH, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 8'h40});
    @(posedge ref_clk);
    put_row('{status_flag_pkg::GRP_LOGIC, 1'b0, 16'h0001, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00});
    irq_accept <= 1'b1;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    irq_accept  <= 1'b0;
    @(negedge ref_clk);
    check({8'h00, status_word}, 16'h0000);
    check({15'h0000, push_valid}, 16'h0001);
    check({8'h00, push_data}, 16'h0040);
    @(negedge ref_clk);
    check({15'h0000, push_valid}, 16'h0000);
    // Restore beats a retiring instruction; pad bits stay low
    @(posedge ref_clk);
    put_row('{status_flag_pkg::GRP_DROP_CARRY, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00});
    reti_valid   <= 1'b1;
    restore_data <= 8'hff;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    reti_valid  <= 1'b0;
    @(negedge ref_clk);
    check({8'h00, status_word}, 16'h007d);
    // Reset in mid-run clears the word again
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    check({8'h00, status_word}, 16'h0000);
    check({8'h00, push_data}, 16'h0000);
    final_report();
  end
endmodule
